// file: include/shr_defs.vh
// Constants for the host controller register front end.
`ifndef SHR_DEFS_VH
`define SHR_DEFS_VH
// Configuration space byte offsets.
`define SHR_CFG_BASE0   8'h20
`define SHR_CFG_BASE1   8'h21
`define SHR_CFG_SVID0   8'h2C
`define SHR_CFG_SVID1   8'h2D
`define SHR_CFG_SID0    8'h2E
`define SHR_CFG_SID1    8'h2F
`define SHR_CFG_ILINE   8'h3C
`define SHR_CFG_IPIN    8'h3D
`define SHR_CFG_HCFG    8'h40
// I/O window offsets.
`define SHR_IO_STATUS   4'h0
`define SHR_IO_CONTROL  4'h2
`define SHR_IO_CMDCODE  4'h3
`define SHR_IO_TARGET   4'h4
`define SHR_IO_DATA0    4'h5
`define SHR_IO_DATA1    4'h6
`define SHR_IO_BLOCK    4'h7
// Reset and fixed values.
`define SHR_IPIN_VALUE  8'h02
`define SHR_BASE_RST    12'h000
`define SHR_BYTE_RST    8'h00
// Host status bit positions.
`define SHR_ST_BYTE     7
`define SHR_ST_INUSE    6
`define SHR_ST_ALERT    5
`define SHR_ST_FAILED   4
`define SHR_ST_BUSERR   3
`define SHR_ST_DEVERR   2
`define SHR_ST_DONE     1
`define SHR_ST_BUSY     0
// Host control and configuration bit positions.
`define SHR_HC_IRQEN    0
`define SHR_HC_KILL     1
`define SHR_HC_SEL_LO   2
`define SHR_HC_SEL_HI   4
`define SHR_HC_LAST     5
`define SHR_HC_START    6
`define SHR_CF_ENABLE   0
`define SHR_CF_SMI      1
`define SHR_CF_I2C      2
// First reserved command code.
`define SHR_SEL_FIRST_BAD 3'h6
`endif

// file: verilog/shr_regs.v
// Register front end and status logic of the two-wire bus host controller.
`timescale 1ns/1ps
`include "shr_defs.vh"

// Every access is a single-cycle request and is answered on the next edge.
// The answer comes whether or not the request hits a register, so a
// master never waits on a miss or on a disabled I/O window.
// Configuration space is decoded on the low address byte only.
// The I/O window is sixteen bytes wide and moves with the base register.
// Status flags are sticky: hardware sets them and software writes ones
// to clear them. A set in the same cycle as a clear wins, so an event
// that lands during the clear is never lost.
// The alert flag sits in the resume well and so outlives a core reset.
// Any pending flag except byte-done holds the interrupt pin and also bars new starts.
// That keeps software from stacking commands on an unserviced result.
// The bus engine itself lives outside this block; it sees only the
// start, abort and block write strobes and the stored command fields.

module shr_regs #(
  parameter [15:0] SUBSYS_VENDOR = 16'h5A5A, // Arbitrary identity value.
  parameter [15:0] SUBSYS_ID     = 16'hA5C3  // Arbitrary identity value.
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        resume_reset_n,
  input  wire        acc_valid,
  input  wire        acc_write,
  input  wire        acc_io,
  input  wire [15:0] acc_addr,
  input  wire [7:0]  acc_wdata,
  input  wire        io_space_en,
  input  wire        alert_is_gpio,
  input  wire        ev_alert,
  input  wire        ev_byte,
  input  wire        ev_heartbeat,
  input  wire        ev_collision,
  input  wire        ev_device_error_flag,
  input  wire        ev_done_ok,
  input  wire        eng_load,
  input  wire [7:0]  eng_d0,
  input  wire [7:0]  eng_d1,
  input  wire        blk_rx_valid,
  input  wire [7:0]  blk_rx_data,
  output reg  [7:0]  acc_rdata_q,
  output reg         acc_ack_q,
  output reg         cmd_start_q,
  output reg         cmd_abort_q,
  output reg         blk_wr_stb_q,
  output wire [2:0]  command_select,
  output wire        last_byte,
  output wire        i2c_mode,
  output wire [7:0]  command_code,
  output wire [7:0]  target_address,
  output wire [7:0]  data_byte_0,
  output wire [7:0]  data_byte_1,
  output wire [7:0]  block_data,
  output wire        busy,
  output reg         pci_irq_line_b_n,
  output reg         system_mgmt_irq_n
);

  // Flag update: a hardware set in the same cycle as a clear wins.
  function w1c_next;
    input cur;
    input set;
    input clr;
    begin
      w1c_next = set | (cur & ~clr);
    end
  endfunction

  // Offset match inside the I/O window, shared by the command, target, data, block and status-read strobes.
  function io_match;
    input [3:0] off;
    input [3:0] want;
    begin
      io_match = (off == want);
    end
  endfunction

  reg [11:0] base_q;
  reg [7:0]  iline_q;
  reg [2:0]  hcfg_q;
  reg [5:0]  hctl_q;
  reg [7:0]  cmdcode_q;
  reg [7:0]  target_q;
  reg [7:0]  data0_q;
  reg [7:0]  data1_q;
  reg [7:0]  block_q;
  reg        byte_done_q;
  reg        inuse_q;
  reg        alert_q;
  reg        failed_q;
  reg        bus_err_q;
  reg        device_error_flag_q;
  reg        done_q;
  reg        busy_q;

  wire       cfg_acc;
  wire       io_hit;
  wire [3:0] io_off;
  wire       io_wr;
  wire       io_rd;
  wire       cfg_wr;
  wire [7:0] st_clr;
  wire       ctl_wr;
  wire       any_flag;
  wire       start_req;
  wire       start_bad;
  wire       start_ok;
  wire       kill_req;
  wire       route_smi;
  wire       wr_cmd;
  wire       wr_tgt;
  wire       wr_d0;
  wire       wr_d1;
  wire       wr_blk;
  wire       rd_sta;

  // Access decode: config space by low byte, I/O space by the base window.
  assign cfg_acc = acc_valid & ~acc_io;
  assign io_hit  = acc_valid & acc_io & io_space_en &
                   (acc_addr[15:4] == base_q);
  assign io_off  = acc_addr[3:0];
  assign io_wr   = io_hit & acc_write;
  assign io_rd   = io_hit & ~acc_write;
  assign cfg_wr  = cfg_acc & acc_write;

  // Per-register strobes; the status clear, control write and read mux repeat their own offset decodes.
  assign wr_cmd = io_wr & io_match(io_off, `SHR_IO_CMDCODE);
  assign wr_tgt = io_wr & io_match(io_off, `SHR_IO_TARGET);
  assign wr_d0  = io_wr & io_match(io_off, `SHR_IO_DATA0);
  assign wr_d1  = io_wr & io_match(io_off, `SHR_IO_DATA1);
  assign wr_blk = io_wr & io_match(io_off, `SHR_IO_BLOCK);
  assign rd_sta = io_rd & io_match(io_off, `SHR_IO_STATUS);

  // Write-one-to-clear mask for the status register.
  assign st_clr = (io_wr && io_off == `SHR_IO_STATUS) ?
                  acc_wdata : 8'h00;

  // Pending interrupt sources; the alert flag counts as one.
  assign any_flag = done_q | device_error_flag_q | bus_err_q |
                    failed_q | alert_q;

  // A start is only taken when enabled, idle and nothing is pending.
  assign ctl_wr    = io_wr && (io_off == `SHR_IO_CONTROL);
  assign start_req = ctl_wr & acc_wdata[`SHR_HC_START] &
                     hcfg_q[`SHR_CF_ENABLE] & ~busy_q &
                     ~any_flag;
  assign start_bad = start_req &
    (acc_wdata[`SHR_HC_SEL_HI:`SHR_HC_SEL_LO] >=
     `SHR_SEL_FIRST_BAD);
  assign start_ok  = start_req & ~start_bad;
  assign kill_req  = ctl_wr & acc_wdata[`SHR_HC_KILL] & busy_q;

  // Management interrupt routing needs both the config and enable bits.
  assign route_smi = hcfg_q[`SHR_CF_SMI] &
                     hctl_q[`SHR_HC_IRQEN];

  // Outputs straight from the stored registers.
  assign command_select = hctl_q[`SHR_HC_SEL_HI:`SHR_HC_SEL_LO];
  assign last_byte      = hctl_q[`SHR_HC_LAST];
  assign i2c_mode       = hcfg_q[`SHR_CF_I2C];
  assign command_code   = cmdcode_q;
  assign target_address = target_q;
  assign data_byte_0    = data0_q;
  assign data_byte_1    = data1_q;
  assign block_data     = block_q;
  assign busy           = busy_q;

  // Configuration space writes; only base, scratch and config hold state.
  always @(posedge clk) begin
    if (!reset_n) begin
      base_q  <= `SHR_BASE_RST;
      iline_q <= `SHR_BYTE_RST;
      hcfg_q  <= 3'h0;
    end else if (cfg_wr) begin
      if (acc_addr[7:0] == `SHR_CFG_BASE0) begin
        base_q[3:0] <= acc_wdata[7:4];
      end else if (acc_addr[7:0] == `SHR_CFG_BASE1) begin
        base_q[11:4] <= acc_wdata;
      end else if (acc_addr[7:0] == `SHR_CFG_ILINE) begin
        iline_q <= acc_wdata;
      end else if (acc_addr[7:0] == `SHR_CFG_HCFG) begin
        hcfg_q <= acc_wdata[2:0];
      end
    end
  end

  // I/O registers written by software; engine results overwrite data.
  // Software is expected to stay away while busy, so the engine wins.
  always @(posedge clk) begin
    if (!reset_n) begin
      hctl_q    <= 6'h00;
      cmdcode_q <= `SHR_BYTE_RST;
      target_q  <= `SHR_BYTE_RST;
      data0_q   <= `SHR_BYTE_RST;
      data1_q   <= `SHR_BYTE_RST;
      block_q   <= `SHR_BYTE_RST;
    end else begin
      if (ctl_wr) begin
        hctl_q <= acc_wdata[5:0];
      end
      if (wr_cmd) begin
        cmdcode_q <= acc_wdata;
      end
      if (wr_tgt) begin
        target_q <= acc_wdata;
      end
      if (eng_load) begin
        data0_q <= eng_d0;
        data1_q <= eng_d1;
      end else begin
        if (wr_d0) begin
          data0_q <= acc_wdata;
        end
        if (wr_d1) begin
          data1_q <= acc_wdata;
        end
      end
      if (blk_rx_valid) begin
        block_q <= blk_rx_data;
      end else if (wr_blk) begin
        block_q <= acc_wdata;
      end
    end
  end

  // Command launch, abort and block write strobes, one cycle each.
  always @(posedge clk) begin
    if (!reset_n) begin
      cmd_start_q  <= 1'b0;
      cmd_abort_q  <= 1'b0;
      blk_wr_stb_q <= 1'b0;
    end else begin
      cmd_start_q  <= start_ok;
      cmd_abort_q  <= kill_req;
      blk_wr_stb_q <= wr_blk;
    end
  end

  // Busy runs from an accepted start to the first terminating event.
  // A start and an end cannot meet: starts are refused while busy.
  always @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (start_ok) begin
      busy_q <= 1'b1;
    end else if (busy_q & (ev_done_ok | ev_device_error_flag |
                           ev_collision | kill_req)) begin
      busy_q <= 1'b0;
    end
  end

  // Sticky status flags kept in the core well.
  always @(posedge clk) begin
    if (!reset_n) begin
      byte_done_q <= 1'b0;
      failed_q    <= 1'b0;
      bus_err_q   <= 1'b0;
      device_error_flag_q   <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      byte_done_q <= w1c_next(byte_done_q,
                       ev_byte & ~ev_heartbeat,
                       st_clr[`SHR_ST_BYTE]);
      failed_q    <= w1c_next(failed_q, kill_req,
                       st_clr[`SHR_ST_FAILED]);
      bus_err_q   <= w1c_next(bus_err_q, busy_q & ev_collision,
                       st_clr[`SHR_ST_BUSERR]);
      device_error_flag_q   <= w1c_next(device_error_flag_q,
                       start_bad | (busy_q & ev_device_error_flag),
                       st_clr[`SHR_ST_DEVERR]);
      done_q      <= w1c_next(done_q,
                       busy_q & ev_done_ok & hctl_q[`SHR_HC_IRQEN],
                       st_clr[`SHR_ST_DONE]);
    end
  end

  // The alert flag lives in the resume well, so only that reset
  // clears it; a core reset leaves a pending alert in place.
  always @(posedge clk) begin
    if (!resume_reset_n) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= w1c_next(alert_q, ev_alert & ~alert_is_gpio,
                          st_clr[`SHR_ST_ALERT]);
    end
  end

  // Ownership semaphore: a status read hands out zero once, then one.
  // A write of one rearms it; it drives no other logic.
  always @(posedge clk) begin
    if (!reset_n) begin
      inuse_q <= 1'b0;
    end else if (st_clr[`SHR_ST_INUSE]) begin
      inuse_q <= 1'b0;
    end else if (rd_sta) begin
      inuse_q <= 1'b1;
    end
  end

  // Interrupt pins follow the pending flags, steered by the routing.
  // Registered to keep the pins glitch free; this costs one cycle.
  always @(posedge clk) begin
    if (!reset_n) begin
      pci_irq_line_b_n  <= 1'b1;
      system_mgmt_irq_n <= 1'b1;
    end else begin
      pci_irq_line_b_n  <= ~(any_flag & ~route_smi);
      system_mgmt_irq_n <= ~(any_flag & route_smi);
    end
  end

  // Read data and acknowledge, one cycle after the request.
  // Unmapped offsets and reserved bits read as zero.
  always @(posedge clk) begin
    if (!reset_n) begin
      acc_rdata_q <= 8'h00;
      acc_ack_q   <= 1'b0;
    end else begin
      acc_ack_q   <= acc_valid;
      acc_rdata_q <= 8'h00;
      if (cfg_acc && !acc_write) begin
        if (acc_addr[7:0] == `SHR_CFG_BASE0) begin
          acc_rdata_q <= {base_q[3:0], 4'h1};
        end else if (acc_addr[7:0] == `SHR_CFG_BASE1) begin
          acc_rdata_q <= base_q[11:4];
        end else if (acc_addr[7:0] == `SHR_CFG_SVID0) begin
          acc_rdata_q <= SUBSYS_VENDOR[7:0];
        end else if (acc_addr[7:0] == `SHR_CFG_SVID1) begin
          acc_rdata_q <= SUBSYS_VENDOR[15:8];
        end else if (acc_addr[7:0] == `SHR_CFG_SID0) begin
          acc_rdata_q <= SUBSYS_ID[7:0];
        end else if (acc_addr[7:0] == `SHR_CFG_SID1) begin
          acc_rdata_q <= SUBSYS_ID[15:8];
        end else if (acc_addr[7:0] == `SHR_CFG_ILINE) begin
          acc_rdata_q <= iline_q;
        end else if (acc_addr[7:0] == `SHR_CFG_IPIN) begin
          acc_rdata_q <= `SHR_IPIN_VALUE;
        end else if (acc_addr[7:0] == `SHR_CFG_HCFG) begin
          acc_rdata_q <= {5'h00, hcfg_q};
        end
      end else if (io_rd) begin
        if (io_off == `SHR_IO_STATUS) begin
          acc_rdata_q <= {byte_done_q, inuse_q, alert_q, failed_q,
                          bus_err_q, device_error_flag_q, done_q, busy_q};
        end else if (io_off == `SHR_IO_CONTROL) begin
          // Start and last-byte are write-only and read zero.
          acc_rdata_q <= {3'h0, hctl_q[4:0]};
        end else if (io_off == `SHR_IO_CMDCODE) begin
          acc_rdata_q <= cmdcode_q;
        end else if (io_off == `SHR_IO_TARGET) begin
          acc_rdata_q <= target_q;
        end else if (io_off == `SHR_IO_DATA0) begin
          acc_rdata_q <= data0_q;
        end else if (io_off == `SHR_IO_DATA1) begin
          acc_rdata_q <= data1_q;
        end else if (io_off == `SHR_IO_BLOCK) begin
          acc_rdata_q <= block_q;
        end
      end
    end
  end

endmodule // shr_regs

// file: verif/shr_regs_sva.sv
// Concurrent checks on the ports of the register front end.
`timescale 1ns/1ps
module shr_regs_chk (
  input wire        clk,
  input wire        reset_n,
  input wire        acc_valid,
  input wire        acc_write,
  input wire        acc_io,
  input wire [15:0] acc_addr,
  input wire [7:0]  acc_wdata,
  input wire [7:0]  acc_rdata_q,
  input wire        acc_ack_q,
  input wire        cmd_start_q,
  input wire        cmd_abort_q,
  input wire        busy,
  input wire        ev_done_ok,
  input wire        pci_irq_line_b_n,
  input wire        system_mgmt_irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Request kinds; an I/O miss answers zero, so no base compare is needed.
  wire base_rd = acc_valid && !acc_write && !acc_io && acc_addr[7:0] == 8'h20;
  wire ctl_rd  = acc_valid && !acc_write && acc_io && acc_addr[3:0] == 4'h2;
  wire ctl_wr  = acc_valid && acc_write && acc_io && acc_addr[3:0] == 4'h2;
  wire sta_rd  = acc_valid && !acc_write && acc_io && acc_addr[3:0] == 4'h0;
  wire irq_on  = !pci_irq_line_b_n || !system_mgmt_irq_n;
  ack_timing_a: assert property (acc_valid |=> acc_ack_q)
    else $error("access not answered next cycle");
  base_flag_a: assert property (base_rd |=> acc_rdata_q[3:0] == 4'h1)
    else $error("base low nibble wrong");
  start_zero_a: assert property (ctl_rd |=> !acc_rdata_q[6])
    else $error("start bit read back as one");
  busy_refuse_a: assert property (ctl_wr && acc_wdata[6] && busy
    |=> !cmd_start_q) else $error("start accepted while busy");
  start_busy_a: assert property (cmd_start_q |-> busy && !$past(busy))
    else $error("start without busy rising");
  done_idle_a: assert property (ev_done_ok && busy |=> !busy)
    else $error("busy held after completion");
  kill_irq_a: assert property (cmd_abort_q && !acc_valid |=> irq_on)
    else $error("kill raised no interrupt");
  irq_hold_a: assert property (acc_ack_q && $past(sta_rd)
    && $past(reset_n, 3) && (|acc_rdata_q[5:1]) |-> irq_on)
    else $error("flag set but interrupt idle");
  cover property (cmd_start_q);
  cover property (cmd_abort_q);
  cover property (!system_mgmt_irq_n);
endmodule // shr_regs_chk

bind shr_regs shr_regs_chk chk_u (.clk(clk), .reset_n(reset_n),
  .acc_valid(acc_valid), .acc_write(acc_write), .acc_io(acc_io),
  .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata_q(acc_rdata_q),
  .acc_ack_q(acc_ack_q), .cmd_start_q(cmd_start_q),
  .cmd_abort_q(cmd_abort_q), .busy(busy), .ev_done_ok(ev_done_ok),
  .pci_irq_line_b_n(pci_irq_line_b_n),
  .system_mgmt_irq_n(system_mgmt_irq_n));

// file: verif/shr_engine_model.sv
// Behavioural bus engine and target stand-in that answers host commands.
`timescale 1ns/1ps
module shr_engine_model (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       cmd_start_q,
  input  wire       cmd_abort_q,
  input  wire [1:0] mode,
  input  wire       hb,
  output reg        ev_byte,
  output reg        ev_heartbeat,
  output reg        ev_done_ok,
  output reg        ev_device_error_flag,
  output reg        ev_collision,
  output reg        eng_load
);
  reg [3:0] cnt_q = 4'h0;
  // Mode 0 completes, 1 finds no target, 2 loses arbitration, 3 hangs
  // until killed, so the kill path can be reached at all.
  always @(posedge clk) begin
    if (!reset_n || cmd_abort_q)
      cnt_q <= #1 4'h0;
    else if (cmd_start_q)
      cnt_q <= #1 4'h6;
    else if (cnt_q != 4'h0 && mode != 2'h3)
      cnt_q <= #1 cnt_q - 4'h1;
  end
  // One-cycle pulses; the byte comes one cycle before the ending event.
  always @* begin
    ev_byte = cnt_q == 4'h3;
    ev_heartbeat = ev_byte && hb;
    ev_done_ok = cnt_q == 4'h2 && mode == 2'h0;
    ev_device_error_flag = cnt_q == 4'h2 && mode == 2'h1;
    ev_collision = cnt_q == 4'h2 && mode == 2'h2;
    eng_load = cnt_q == 4'h2;
  end
endmodule // shr_engine_model

// file: verif/test_shr_regs.sv
// Self-checking testbench for the register front end.
`timescale 1ns/1ps
module test_shr_regs;
  localparam [15:0] SV = 16'h1B2D; // Arbitrary identity value.
  localparam [15:0] SI = 16'h6E47; // Arbitrary identity value.
  reg        clk = 0, reset_n = 0, resume_reset_n = 0, ev_alert = 0;
  reg        acc_valid = 0, acc_write = 0, acc_io = 0, io_space_en = 1;
  reg        alert_is_gpio = 0, hb = 0, smi_on = 0;
  reg [1:0]  mode = 2'h0;
  reg [15:0] acc_addr = 16'h0000, base = 16'h0000;
  reg [7:0]  acc_wdata = 8'h00, rd;
  integer    n_fail = 0, compares = 0, i;
  wire       ev_byte, ev_heartbeat, ev_done_ok, ev_device_error_flag, ev_collision;
  wire       eng_load, cmd_start_q, cmd_abort_q, acc_ack_q, i2c_mode, busy;
  wire       pci_irq_line_b_n, system_mgmt_irq_n, last_byte, blk_wr_stb;
  wire [7:0] command_code, target_address;
  reg        stb;
  wire [7:0] acc_rdata_q, data_byte_0, data_byte_1, block_data;
  wire [2:0] command_select;
  always #25 clk = ~clk;
  shr_regs #(.SUBSYS_VENDOR(SV), .SUBSYS_ID(SI)) dut_u (.clk(clk),
    .reset_n(reset_n), .resume_reset_n(resume_reset_n),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_io(acc_io),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .io_space_en(io_space_en),
    .alert_is_gpio(alert_is_gpio), .ev_alert(ev_alert), .ev_byte(ev_byte),
    .ev_heartbeat(ev_heartbeat), .ev_collision(ev_collision),
    .ev_device_error_flag(ev_device_error_flag), .ev_done_ok(ev_done_ok), .eng_load(eng_load),
    .eng_d0(8'hA7), .eng_d1(8'hC3), .blk_rx_valid(ev_byte),
    .blk_rx_data(8'h3C), .acc_rdata_q(acc_rdata_q), .acc_ack_q(acc_ack_q),
    .cmd_start_q(cmd_start_q), .cmd_abort_q(cmd_abort_q),
    .blk_wr_stb_q(blk_wr_stb), .command_select(command_select),
    .last_byte(last_byte), .i2c_mode(i2c_mode),
    .command_code(command_code), .target_address(target_address),
    .data_byte_0(data_byte_0), .data_byte_1(data_byte_1),
    .block_data(block_data), .busy(busy),
    .pci_irq_line_b_n(pci_irq_line_b_n),
    .system_mgmt_irq_n(system_mgmt_irq_n));
  shr_engine_model bus_u (.clk(clk), .reset_n(reset_n), .mode(mode),
    .cmd_start_q(cmd_start_q), .cmd_abort_q(cmd_abort_q), .hb(hb),
    .ev_byte(ev_byte), .ev_heartbeat(ev_heartbeat), .eng_load(eng_load),
    .ev_done_ok(ev_done_ok), .ev_device_error_flag(ev_device_error_flag),
    .ev_collision(ev_collision));
  // Single comparison point; every mismatch is counted and reported.
  task check(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // One access, held until the taking edge; the answer is caught with ack.
  task acc(input wr, input io, input [15:0] a, input [7:0] d);
    begin
      acc_valid = 1;
      acc_write = wr;
      acc_io = io;
      acc_addr = a;
      acc_wdata = d;
      @(posedge clk);
      #1 acc_valid = 0;
      rd = acc_rdata_q;
      stb = blk_wr_stb;
      check({7'h00, acc_ack_q}, 8'h01);
      @(posedge clk);
      #1;
    end
  endtask
  task cr(input [7:0] a, input [7:0] e);
    begin
      acc(1'b0, 1'b0, {8'h00, a}, 8'h00);
      check(rd, e);
    end
  endtask
  task ir(input [3:0] a, input [7:0] e);
    begin
      acc(1'b0, 1'b1, base | {12'h000, a}, 8'h00);
      check(rd, e);
    end
  endtask
  task cw(input [7:0] a, input [7:0] d);
    acc(1'b1, 1'b0, {8'h00, a}, d);
  endtask
  task iw(input [3:0] a, input [7:0] d);
    acc(1'b1, 1'b1, base | {12'h000, a}, d);
  endtask
  // Expected pin levels follow from flags 5..1 and the routing choice.
  task pins(input [7:0] f);
    check({6'h00, pci_irq_line_b_n, system_mgmt_irq_n},
      {6'h00, ~(|f[5:1] & ~smi_on), ~(|f[5:1] & smi_on)});
  endtask
  // Runs one command to its end, checks status and pins, then clears.
  task run(input [7:0] ctl, input [1:0] m, input h, input [7:0] e);
    begin
      mode = m;
      hb = h;
      iw(4'h2, ctl);
      check({7'h00, busy}, {7'h00, ctl[4:3] != 2'b11});
      for (i = 0; i < 40 && busy !== 1'b0; i = i + 1)
        @(posedge clk);
      #1 ir(4'h0, e);
      pins(e);
      iw(4'h0, 8'hBF);
      ir(4'h0, 8'h40);
      pins(8'h00);
    end
  endtask
  task t_reset;
    begin
      cr(8'h20, 8'h01);
      cr(8'h22, 8'h00);
      cr(8'h2C, SV[7:0]);
      cr(8'h2D, SV[15:8]);
      cr(8'h2E, SI[7:0]);
      cr(8'h2F, SI[15:8]);
      cr(8'h3C, 8'h00);
      cr(8'h3D, 8'h02);
      ir(4'h0, 8'h00);
    end
  endtask
  task t_base;
    begin
      cw(8'h20, 8'hF5);
      cw(8'h21, 8'h12);
      cw(8'h3C, 8'h96);
      base = 16'h12F0;
      cr(8'h20, 8'hF1);
      cr(8'h21, 8'h12);
      cr(8'h3C, 8'h96);
      ir(4'h0, 8'h40);
      iw(4'h0, 8'h40);
      ir(4'h0, 8'h00);
      ir(4'h0, 8'h40);
      io_space_en = 0;
      ir(4'h0, 8'h00);
      io_space_en = 1;
    end
  endtask
  // Plain data registers, write-only control bits and their outputs.
  task t_regs;
    begin
      iw(4'h3, 8'h5E);
      iw(4'h4, 8'hB4);
      iw(4'h7, 8'h69);
      check({7'h00, stb}, 8'h01);
      ir(4'h3, 8'h5E);
      ir(4'h4, 8'hB4);
      ir(4'h7, 8'h69);
      check({7'h00, stb}, 8'h00);
      check(command_code, 8'h5E);
      check(target_address, 8'hB4);
      iw(4'h2, 8'h74);
      check({7'h00, last_byte}, 8'h01);
      check({5'h00, command_select}, 8'h05);
      check({7'h00, busy}, 8'h00);
      ir(4'h2, 8'h14);
      iw(4'h2, 8'h00);
      check({7'h00, last_byte}, 8'h00);
    end
  endtask
  task t_cmds;
    begin
      cw(8'h40, 8'h01);
      run(8'h49, 2'h0, 1'b0, 8'hC2);
      ir(4'h2, 8'h09);
      run(8'h48, 2'h0, 1'b0, 8'hC0);
      run(8'h55, 2'h0, 1'b1, 8'h42);
      run(8'h55, 2'h1, 1'b0, 8'hC4);
      run(8'h4D, 2'h2, 1'b0, 8'hC8);
      run(8'h59, 2'h0, 1'b0, 8'h44);
      run(8'h5D, 2'h0, 1'b0, 8'h44);
      check(data_byte_0, 8'hA7);
      check(data_byte_1, 8'hC3);
      check(block_data, 8'h3C);
      smi_on = 1;
      cw(8'h40, 8'h07);
      check({7'h00, i2c_mode}, 8'h01);
      run(8'h49, 2'h0, 1'b0, 8'hC2);
      smi_on = 0;
      cw(8'h40, 8'h01);
    end
  endtask
  task t_kill;
    begin
      iw(4'h2, 8'h49);
      for (i = 0; i < 40 && busy !== 1'b0; i = i + 1)
        @(posedge clk);
      #1 iw(4'h2, 8'h49);
      check({7'h00, busy}, 8'h00);
      iw(4'h0, 8'hBF);
      cw(8'h40, 8'h00);
      iw(4'h2, 8'h49);
      check({7'h00, busy}, 8'h00);
      cw(8'h40, 8'h01);
      mode = 2'h3;
      iw(4'h2, 8'h49);
      iw(4'h2, 8'h0B);
      check({7'h00, busy}, 8'h00);
      ir(4'h0, 8'h50);
      pins(8'h50);
      iw(4'h0, 8'hBF);
      mode = 2'h0;
    end
  endtask
  // Alert survives the core reset and falls only to the resume reset.
  task t_alert;
    begin
      alert_is_gpio = 1;
      ev_alert = 1;
      @(posedge clk);
      #1 ev_alert = 0;
      ir(4'h0, 8'h40);
      alert_is_gpio = 0;
      ev_alert = 1;
      @(posedge clk);
      #1 ev_alert = 0;
      ir(4'h0, 8'h60);
      pins(8'h60);
      reset_n = 0;
      @(posedge clk);
      #1 reset_n = 1;
      base = 16'h0000;
      @(posedge clk);
      #1 ir(4'h0, 8'h20);
      resume_reset_n = 0;
      @(posedge clk);
      #1 resume_reset_n = 1;
      ir(4'h0, 8'h40);
    end
  endtask
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Main sequence after three reset cycles.
  initial begin
    repeat (3) @(posedge clk);
    #1 reset_n = 1;
    resume_reset_n = 1;
    @(posedge clk);
    #1 t_reset;
    t_base;
    t_regs;
    t_cmds;
    t_kill;
    t_alert;
    give_verdict;
  end
  // The whole run needs well under 1000 cycles; cut a hang at 4000.
  initial begin
    #200000;
    n_fail = n_fail + 1;
    give_verdict;
  end
endmodule // test_shr_regs
